// >>> core/rccu_defines.svh
// constants for the relay channel command unit: opcodes, status bits, timing
`ifndef RCCU_DEFINES_SVH
`define RCCU_DEFINES_SVH

// action opcodes
`define RCCU_OP_RD_PHYS    8'h00
`define RCCU_OP_RD_PROG    8'h01
`define RCCU_OP_WR_DRV     8'h02
`define RCCU_OP_WR_MODE    8'h03
`define RCCU_OP_RD_MODE    8'h04
`define RCCU_OP_WR_PULSE   8'h05
`define RCCU_OP_RD_PULSE   8'h06

// status byte bit positions
`define RCCU_ST_RESET_BIT  0
`define RCCU_ST_STREAM_ERROR_FLAG_BIT   6
`define RCCU_ST_COMMAND_ERROR_FLAG_BIT   7
`define RCCU_ST_RESET_VAL  8'h01

// channel count and highest legal channel number
`define RCCU_NCHAN         16
`define RCCU_MAX_CHAN      8'h0F

// pulse timing defaults after entering pwm mode
`define RCCU_DEF_ACTIVE    8'h00
`define RCCU_DEF_INACTIVE  8'h01

// timing: 2 ms step at 200 MHz, 10 ms debounce
`define RCCU_CLK_MHZ       200
`define RCCU_TICK_US       2000
`define RCCU_TICK_CYC      (`RCCU_TICK_US * `RCCU_CLK_MHZ)
`define RCCU_TICK_MS       2
`define RCCU_DEB_MS        10
`define RCCU_DEB_SAMPLES   (`RCCU_DEB_MS / `RCCU_TICK_MS)

`endif

// >>> core/rccu_pkg.sv
// types shared by the relay channel command unit
package rccu_pkg;
    typedef logic [15:0] rccu_mask_t;
    typedef logic [7:0]  rccu_byte_t;
    typedef enum logic [1:0] {
        RCCU_IDLE = 2'b01,
        RCCU_ARGS = 2'b10
    } rccu_state_e;
endpackage

// >>> core/rccu_pwm_if.sv
// control and readback signals between command logic and the pwm bank
`timescale 1ns/100ps
interface rccu_pwm_if;
    import rccu_pkg::*;
    logic       tick;
    logic       mod_rst;
    rccu_mask_t mode;
    rccu_mask_t enter;
    logic       wr_en;
    logic [3:0] wr_chan;
    rccu_byte_t wr_on;
    rccu_byte_t wr_off;
    logic [3:0] rd_chan;
    rccu_byte_t rd_on;
    rccu_byte_t rd_off;
    rccu_mask_t pwm_out;
    modport ctl  (output tick, mod_rst, mode, enter, wr_en, wr_chan, wr_on, wr_off, rd_chan,
                  input rd_on, rd_off, pwm_out);
    modport bank (input tick, mod_rst, mode, enter, wr_en, wr_chan, wr_on, wr_off, rd_chan,
                  output rd_on, rd_off, pwm_out);
endinterface

// >>> core/rccu_pwm_bank.sv
// sixteen pulse generators with active/inactive intervals in 2 ms steps
`timescale 1ns/100ps
`include "rccu_defines.svh"
module rccu_pwm_bank (
    input wire logic mclk,    // system clock
    input wire logic reset_n, // async reset, active low
    rccu_pwm_if.bank pb       // control from the command logic
);
    import rccu_pkg::*;

    rccu_byte_t on_w  [`RCCU_NCHAN];
    rccu_byte_t off_w [`RCCU_NCHAN];

    genvar i;
    generate
        for (i = 0; i < `RCCU_NCHAN; i++) begin : g_ch
            rccu_byte_t on_r;
            rccu_byte_t off_r;
            rccu_byte_t cnt_r;
            logic       act_r;

            // one generator; a new interval is only loaded at a phase end
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    on_r  <= `RCCU_DEF_ACTIVE;
                    off_r <= `RCCU_DEF_INACTIVE;
                    cnt_r <= `RCCU_DEF_INACTIVE;
                    act_r <= 1'b0;
                end else if (pb.mod_rst || pb.enter[i]) begin
                    on_r  <= `RCCU_DEF_ACTIVE;
                    off_r <= `RCCU_DEF_INACTIVE;
                    cnt_r <= `RCCU_DEF_INACTIVE;
                    act_r <= 1'b0;
                end else begin
                    if (pb.wr_en && pb.wr_chan == 4'(i)) begin
                        on_r  <= pb.wr_on;
                        off_r <= pb.wr_off;
                    end
                    // running phase ends with its old length
                    if (pb.tick && pb.mode[i]) begin
                        if (cnt_r > 8'h01) begin
                            cnt_r <= cnt_r - 8'h01;
                        end else if (act_r) begin
                            act_r <= 1'b0;
                            cnt_r <= off_r;
                        end else if (on_r != 8'h00) begin
                            act_r <= 1'b1;
                            cnt_r <= on_r;
                        end else begin
                            cnt_r <= off_r;
                        end
                    end
                end
            end

            assign on_w[i]       = on_r;
            assign off_w[i]      = off_r;
            assign pb.pwm_out[i] = act_r;
        end
    endgenerate

    // timing readback of the addressed channel
    assign pb.rd_on  = on_w[pb.rd_chan];
    assign pb.rd_off = off_w[pb.rd_chan];
endmodule

// >>> core/rccu_top.sv
// relay channel command unit: action decoder, debounce, drivers, flags
// Operation
// - module reset sets all channels standard and all drivers inactive
// - reset on power-up, watchdog, restart action or communication timeout
// - stream error flag is set on a drive stream fault, cleared by flag clear
// - opcode 00 returns debounced physical states, two bytes, low first
// - physical states sampled every 2 ms, debounced over 10 ms
// - physical states are reported for all channels in any mode
// - opcode 01 returns programmed driver states, two bytes, low first
// - opcode 02 writes driver states of standard channels only, no response
// - driver update is deferred and lands within 2 ms
// - all drivers changed by one write switch together
// - opcode 03 writes channel modes, one is pwm, no response
// - entering pwm mode clears the duty cycle to zero
// - entering standard mode forces the driver inactive
// - opcode 04 returns channel modes, two bytes, low first
// - opcode 05 carries channel, active and inactive intervals, no response
// - pulse timing writes to standard channels are ignored
// - channel above 15 in pulse timing actions sets command error
// - inactive interval zero becomes one; active zero keeps output inactive
// - a running phase finishes with its old length after a timing write
// - pwm drives active then inactive intervals in 2 ms steps, repeating
// - opcode 06 returns the channel's intervals in effect, defaults if unwritten
// - standard drivers follow written state; pwm drivers follow the generator
`timescale 1ns/100ps
`include "rccu_defines.svh"
module rccu_top #(
    parameter int unsigned TICK_CYCLES = `RCCU_TICK_CYC // clocks per 2 ms step
) (
    input  wire logic              mclk,            // 200 MHz clock
    input  wire logic              reset_n,         // power-up reset, active low
    input  wire logic              cmd_valid,       // action byte strobe
    input  wire logic              cmd_first,       // byte is an opcode
    input  wire rccu_pkg::rccu_byte_t cmd_byte,     // action byte
    input  wire logic              restart_req,     // soft or hard restart action pulse
    input  wire logic              wdog_timeout,    // watchdog expiry pulse
    input  wire logic              clear_flags,     // flag clearing action pulse
    input  wire logic [15:0]       comm_wdog_ticks, // comm timeout in 2 ms steps, 0 off
    input  wire rccu_pkg::rccu_mask_t chan_phys_in, // physical channel states, pins
    input  wire logic              drv_chain_fault, // drive stream fault, pin
    output logic                   resp_valid,      // response byte strobe
    output rccu_pkg::rccu_byte_t   resp_byte,       // response byte
    output rccu_pkg::rccu_mask_t   relay_drv,       // relay drivers, one is active
    output rccu_pkg::rccu_byte_t   status_byte      // module status flags
);
    import rccu_pkg::*;

    rccu_pwm_if pif ();

    // argument bytes per opcode
    function automatic logic [1:0] arg_count(input rccu_byte_t op);
        unique case (op)
            `RCCU_OP_WR_DRV, `RCCU_OP_WR_MODE: arg_count = 2'd2;
            `RCCU_OP_WR_PULSE:                 arg_count = 2'd3;
            `RCCU_OP_RD_PULSE:                 arg_count = 2'd1;
            default:                           arg_count = 2'd0;
        endcase
    endfunction

    logic [31:0] tick_cnt_r;
    logic        tick_r;
    rccu_mask_t  phys_s1_r, phys_s2_r, phys_s3_r, phys_q_r;
    logic        flt_s1_r, flt_s2_r, flt_s3_r, flt_q_r;
    rccu_mask_t  deb_r;
    logic [15:0] comm_cnt_r;
    logic        comm_to;
    logic        mod_rst_r;
    rccu_state_e state_r;
    rccu_byte_t  op_r, arg0_r, arg1_r, arg2_r;
    logic [1:0]  need_r, idx_r;
    logic        exec_r;
    rccu_mask_t  mode_r, prog_r, applied_r;
    logic        upd_pend_r;
    logic        resp_hi_pend_r;
    rccu_byte_t  resp_hi_r;
    logic        command_error_flag_set;
    logic        chan_ok;
    rccu_byte_t  off_clamp;
    rccu_mask_t  wr_mask;

    // 2 ms step enable
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            tick_r     <= 1'b0;
        end
    end

    // pin synchronisers; a bit moves only when stages two and three agree
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phys_s1_r <= 16'h0000;
            phys_s2_r <= 16'h0000;
            phys_s3_r <= 16'h0000;
            phys_q_r  <= 16'h0000;
            flt_s1_r  <= 1'b0;
            flt_s2_r  <= 1'b0;
            flt_s3_r  <= 1'b0;
            flt_q_r   <= 1'b0;
        end else begin
            phys_s1_r <= chan_phys_in;
            phys_s2_r <= phys_s1_r;
            phys_s3_r <= phys_s2_r;
            phys_q_r  <= (phys_s2_r & phys_s3_r) | (phys_q_r & (phys_s2_r ^ phys_s3_r));
            flt_s1_r  <= drv_chain_fault;
            flt_s2_r  <= flt_s1_r;
            flt_s3_r  <= flt_s2_r;
            if (flt_s2_r == flt_s3_r) begin
                flt_q_r <= flt_s3_r;
            end
        end
    end

    // debounce: five agreeing 2 ms samples, so reports are 10 to 12 ms old
    genvar g;
    generate
        for (g = 0; g < `RCCU_NCHAN; g++) begin : g_deb
            logic [`RCCU_DEB_SAMPLES-1:0] hist_r;
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    hist_r   <= '0;
                    deb_r[g] <= 1'b0;
                end else if (tick_r) begin
                    hist_r <= {hist_r[`RCCU_DEB_SAMPLES-2:0], phys_q_r[g]};
                    if (&hist_r) begin
                        deb_r[g] <= 1'b1;
                    end else if (~|hist_r) begin
                        deb_r[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // comm watchdog: steps since the last action byte
    assign comm_to = tick_r && (comm_wdog_ticks != 16'h0000)
                     && (comm_cnt_r + 16'h0001 >= comm_wdog_ticks);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            comm_cnt_r <= 16'h0000;
        end else if (cmd_valid || comm_to) begin
            comm_cnt_r <= 16'h0000;
        end else if (tick_r && comm_wdog_ticks != 16'h0000) begin
            comm_cnt_r <= comm_cnt_r + 16'h0001;
        end
    end

    // module reset pulse from any of its sources
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mod_rst_r <= 1'b0;
        end else begin
            mod_rst_r <= wdog_timeout | restart_req | comm_to;
        end
    end

    // byte collector; an opcode always restarts collection
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= RCCU_IDLE;
            op_r    <= 8'h00;
            need_r  <= 2'd0;
            idx_r   <= 2'd0;
            arg0_r  <= 8'h00;
            arg1_r  <= 8'h00;
            arg2_r  <= 8'h00;
            exec_r  <= 1'b0;
        end else begin
            exec_r <= 1'b0;
            if (cmd_valid && cmd_first) begin
                op_r   <= cmd_byte;
                need_r <= arg_count(cmd_byte);
                idx_r  <= 2'd0;
                if (arg_count(cmd_byte) == 2'd0) begin
                    exec_r  <= 1'b1;
                    state_r <= RCCU_IDLE;
                end else begin
                    state_r <= RCCU_ARGS;
                end
            end else if (cmd_valid) begin
                unique case (state_r)
                    RCCU_IDLE: begin
                        state_r <= RCCU_IDLE; // stray argument byte is dropped
                    end
                    RCCU_ARGS: begin
                        unique case (idx_r)
                            2'd0:    arg0_r <= cmd_byte;
                            2'd1:    arg1_r <= cmd_byte;
                            default: arg2_r <= cmd_byte;
                        endcase
                        idx_r <= idx_r + 2'd1;
                        if (idx_r + 2'd1 == need_r) begin
                            exec_r  <= 1'b1;
                            state_r <= RCCU_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // pulse timing command checks
    assign chan_ok   = (arg0_r <= `RCCU_MAX_CHAN);
    assign off_clamp = (arg2_r == 8'h00) ? 8'h01 : arg2_r;
    assign command_error_flag_set  = exec_r && (((op_r == `RCCU_OP_WR_PULSE || op_r == `RCCU_OP_RD_PULSE)
                       && !chan_ok) || op_r > `RCCU_OP_RD_PULSE);
    assign wr_mask   = {arg1_r, arg0_r};

    // pwm bank control
    assign pif.tick    = tick_r;
    assign pif.mod_rst = mod_rst_r;
    assign pif.mode    = mode_r;
    assign pif.enter   = (exec_r && op_r == `RCCU_OP_WR_MODE) ? (wr_mask & ~mode_r) : 16'h0000;
    assign pif.wr_en   = exec_r && op_r == `RCCU_OP_WR_PULSE && chan_ok
                         && mode_r[arg0_r[3:0]];
    assign pif.wr_chan = arg0_r[3:0];
    assign pif.wr_on   = arg1_r;
    assign pif.wr_off  = off_clamp;
    assign pif.rd_chan = arg0_r[3:0];

    rccu_pwm_bank u_pwm (
        .mclk    (mclk),
        .reset_n (reset_n),
        .pb      (pif)
    );

    // channel modes and programmed states
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r     <= 16'h0000;
            prog_r     <= 16'h0000;
            upd_pend_r <= 1'b0;
        end else if (mod_rst_r) begin
            mode_r     <= 16'h0000;
            prog_r     <= 16'h0000;
            upd_pend_r <= 1'b0;
        end else if (exec_r && op_r == `RCCU_OP_WR_DRV) begin
            prog_r     <= (prog_r & mode_r) | (wr_mask & ~mode_r);
            upd_pend_r <= 1'b1;
        end else if (exec_r && op_r == `RCCU_OP_WR_MODE) begin
            mode_r <= wr_mask;
            prog_r <= prog_r & ~(mode_r & ~wr_mask);
        end else if (tick_r) begin
            upd_pend_r <= 1'b0;
        end
    end

    // applied states move together on the next 2 ms step
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            applied_r <= 16'h0000;
        end else if (mod_rst_r) begin
            applied_r <= 16'h0000;
        end else if (exec_r && op_r == `RCCU_OP_WR_MODE) begin
            applied_r <= applied_r & ~(mode_r & ~wr_mask);
        end else if (tick_r && upd_pend_r) begin
            applied_r <= prog_r;
        end
    end

    // relay drivers: standard follows applied state, pwm follows generator
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            relay_drv <= 16'h0000;
        end else if (mod_rst_r) begin
            relay_drv <= 16'h0000;
        end else begin
            relay_drv <= (applied_r & ~mode_r) | (pif.pwm_out & mode_r);
        end
    end

    // responses: low byte one cycle after execution, high byte the next
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resp_valid     <= 1'b0;
            resp_byte      <= 8'h00;
            resp_hi_pend_r <= 1'b0;
            resp_hi_r      <= 8'h00;
        end else if (exec_r && (op_r == `RCCU_OP_RD_PHYS || op_r == `RCCU_OP_RD_PROG
                     || op_r == `RCCU_OP_RD_MODE || op_r == `RCCU_OP_RD_PULSE)) begin
            resp_valid     <= 1'b1;
            resp_hi_pend_r <= 1'b1;
            unique case (op_r)
                `RCCU_OP_RD_PHYS: begin
                    resp_byte <= deb_r[7:0];
                    resp_hi_r <= deb_r[15:8];
                end
                `RCCU_OP_RD_PROG: begin
                    resp_byte <= prog_r[7:0];
                    resp_hi_r <= prog_r[15:8];
                end
                `RCCU_OP_RD_MODE: begin
                    resp_byte <= mode_r[7:0];
                    resp_hi_r <= mode_r[15:8];
                end
                default: begin
                    resp_byte <= chan_ok ? pif.rd_on : 8'h00;
                    resp_hi_r <= chan_ok ? pif.rd_off : 8'h00;
                end
            endcase
        end else if (resp_hi_pend_r) begin
            resp_valid     <= 1'b1;
            resp_byte      <= resp_hi_r;
            resp_hi_pend_r <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
        end
    end

    // status flags; a new event wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_byte <= `RCCU_ST_RESET_VAL;
        end else begin
            if (clear_flags) begin
                status_byte <= 8'h00;
            end
            if (mod_rst_r) begin
                status_byte[`RCCU_ST_RESET_BIT] <= 1'b1;
            end
            if (flt_q_r) begin
                status_byte[`RCCU_ST_STREAM_ERROR_FLAG_BIT] <= 1'b1;
            end
            if (command_error_flag_set) begin
                status_byte[`RCCU_ST_COMMAND_ERROR_FLAG_BIT] <= 1'b1;
            end
        end
    end
endmodule

// >>> bench/rccu_top_asserts.sv
// concurrent checks on the command unit ports
`timescale 1ns/100ps
module rccu_top_asserts (
    input wire logic                 mclk,            // clock
    input wire logic                 reset_n,         // reset, active low
    input wire logic                 cmd_valid,       // byte strobe
    input wire logic                 cmd_first,       // opcode marker
    input wire rccu_pkg::rccu_byte_t cmd_byte,        // action byte
    input wire logic                 restart_req,     // restart action
    input wire logic                 wdog_timeout,    // watchdog expiry
    input wire logic                 clear_flags,     // flag clear
    input wire logic [15:0]          comm_wdog_ticks, // comm timeout
    input wire rccu_pkg::rccu_mask_t chan_phys_in,    // physical states
    input wire logic                 drv_chain_fault, // stream fault pin
    input wire logic                 resp_valid,      // response strobe
    input wire rccu_pkg::rccu_byte_t resp_byte,       // response byte
    input wire rccu_pkg::rccu_mask_t relay_drv,       // drivers
    input wire rccu_pkg::rccu_byte_t status_byte      // status
);
    import rccu_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // reset values at the first edge after release
    property p_rst_rel; $rose(reset_n) |-> relay_drv == 16'h0000 && status_byte == 8'h01; endproperty
    a_rst_rel: assert property (p_rst_rel) else $error("bad state after reset");
    // module reset is registered, so drivers clear two edges on
    property p_mod_rst; restart_req || wdog_timeout |-> ##2 relay_drv == 16'h0000 && status_byte[0]; endproperty
    a_mod_rst: assert property (p_mod_rst) else $error("module reset missed");
    // synchroniser delay, hence six cycles
    property p_stream_error_flag_set; drv_chain_fault [*6] |-> status_byte[6]; endproperty
    a_stream_error_flag_set: assert property (p_stream_error_flag_set) else $error("stream flag not set");
    property p_stream_error_flag_hold; status_byte[6] && !clear_flags |=> status_byte[6]; endproperty
    a_stream_error_flag_hold: assert property (p_stream_error_flag_hold) else $error("stream flag lost");
    property p_command_error_flag_op; cmd_valid && cmd_first && cmd_byte > 8'h06 |-> ##[1:4] status_byte[7]; endproperty
    a_command_error_flag_op: assert property (p_command_error_flag_op) else $error("bad opcode not flagged");
    property p_command_error_flag_hold; status_byte[7] && !clear_flags |=> status_byte[7]; endproperty
    a_command_error_flag_hold: assert property (p_command_error_flag_hold) else $error("command flag lost");
    property p_rd_ans; cmd_valid && cmd_first && cmd_byte inside {8'h00, 8'h01, 8'h04}
        |-> !resp_valid ##2 resp_valid [*2] ##1 !resp_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer timing");
    property p_wr_quiet; cmd_valid && cmd_first && cmd_byte inside {8'h02, 8'h03, 8'h05}
        |=> !resp_valid [*6]; endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");
endmodule
bind rccu_top rccu_top_asserts rccu_top_asserts_i (
    .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
    .cmd_byte(cmd_byte), .restart_req(restart_req), .wdog_timeout(wdog_timeout),
    .clear_flags(clear_flags), .comm_wdog_ticks(comm_wdog_ticks), .chan_phys_in(chan_phys_in),
    .drv_chain_fault(drv_chain_fault), .resp_valid(resp_valid), .resp_byte(resp_byte),
    .relay_drv(relay_drv), .status_byte(status_byte));

// >>> bench/rccu_gw.sv
// gateway model: sends actions, collects responses
`timescale 1ns/100ps
module rccu_gw (
    input  wire logic                 mclk,       // clock
    output logic                      cmd_valid,  // byte strobe
    output logic                      cmd_first,  // opcode marker
    output rccu_pkg::rccu_byte_t      cmd_byte,   // action byte
    input  wire logic                 resp_valid, // response strobe
    input  wire rccu_pkg::rccu_byte_t resp_byte   // response byte
);
    import rccu_pkg::*;
    rccu_byte_t rq[$];
    // idle at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_first = 1'b0;
        cmd_byte  = 8'h00;
    end
    // one byte per strobe, then a gap cycle
    task automatic send(input rccu_byte_t b, input logic f);
        @(posedge mclk) #1;
        cmd_valid = 1'b1;
        cmd_first = f;
        cmd_byte  = b;
        @(posedge mclk) #1;
        cmd_valid = 1'b0;
        cmd_byte  = ~b; // stale byte inverted
    endtask
    // opcode then its argument bytes
    task automatic act(input rccu_byte_t op, input int n, input rccu_byte_t a0, a1, a2);
        send(op, 1'b1);
        if (n > 0) send(a0, 1'b0);
        if (n > 1) send(a1, 1'b0);
        if (n > 2) send(a2, 1'b0);
    endtask
    // keep each response byte
    always @(posedge mclk) begin
        if (resp_valid === 1'b1) rq.push_back(resp_byte);
    end
endmodule

// >>> bench/rccu_tb.sv
// self-checking bench for the relay channel command unit
`timescale 1ns/100ps
module testbench;
    import rccu_pkg::*;
    localparam int TK = 20; // short 2 ms step
    logic       mclk, reset_n, restart_req, wdog_timeout, clear_flags, drv_chain_fault;
    logic       cmd_valid, cmd_first, resp_valid;
    logic [15:0] comm_wdog_ticks, v;
    rccu_byte_t cmd_byte, resp_byte, status_byte;
    rccu_mask_t chan_phys_in, relay_drv;
    int         bad_count, checked, cyc, hi;
    rccu_top #(.TICK_CYCLES(TK)) rccu_top_i (.mclk(mclk), .reset_n(reset_n),
        .cmd_valid(cmd_valid), .cmd_first(cmd_first), .cmd_byte(cmd_byte),
        .restart_req(restart_req), .wdog_timeout(wdog_timeout), .clear_flags(clear_flags),
        .comm_wdog_ticks(comm_wdog_ticks), .chan_phys_in(chan_phys_in),
        .drv_chain_fault(drv_chain_fault), .resp_valid(resp_valid), .resp_byte(resp_byte),
        .relay_drv(relay_drv), .status_byte(status_byte));
    rccu_gw rccu_gw_i (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_first(cmd_first),
        .cmd_byte(cmd_byte), .resp_valid(resp_valid), .resp_byte(resp_byte));
    // 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // hang guard, run needs ~800 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked = checked + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out();
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        @(posedge mclk) #1 s = 1'b1;
        @(posedge mclk) #1 s = 1'b0;
    endtask
    // read action; a wrong byte count yields unknown
    task automatic rd(input rccu_byte_t op, input int n, input rccu_byte_t a);
        rccu_gw_i.rq.delete();
        rccu_gw_i.act(op, n, a, 8'h00, 8'h00);
        wt(5);
        v = (rccu_gw_i.rq.size() == 2) ? {rccu_gw_i.rq[1], rccu_gw_i.rq[0]} : 16'hXXXX;
    endtask
    task automatic t_drv();
        rccu_gw_i.act(8'h02, 2, 8'hA5, 8'h3C, 8'h00);
        chk(relay_drv, 16'h0000);
        // each cycle shows whole old or whole new pattern
        for (int i = 0; i < TK + 4; i++) begin
            wt(1);
            if (relay_drv !== 16'h0000) chk(relay_drv, 16'h3CA5);
        end
        chk(relay_drv, 16'h3CA5);
        rd(8'h01, 0, 8'h00);
        chk(v, 16'h3CA5);
    endtask
    task automatic t_pwm();
        rccu_gw_i.act(8'h03, 2, 8'h01, 8'h80, 8'h00);
        wt(2 * TK);
        chk(relay_drv, 16'h3CA4);
        rd(8'h04, 0, 8'h00);
        chk(v, 16'h8001);
        rccu_gw_i.act(8'h02, 2, 8'hFF, 8'hFF, 8'h00);
        wt(TK + 4);
        chk(relay_drv, 16'h7FFE);
        rd(8'h06, 1, 8'h00);
        chk(v, 16'h0100);
        rccu_gw_i.act(8'h05, 3, 8'h00, 8'h02, 8'h00);
        rd(8'h06, 1, 8'h00);
        chk(v, 16'h0102);
        rccu_gw_i.act(8'h05, 3, 8'h01, 8'h00, 8'h01);
        wt(3 * TK);
        // two periods of three steps, two active
        hi = 0;
        repeat (6 * TK) begin
            wt(1);
            if (relay_drv[0] === 1'b1) hi = hi + 1;
        end
        chk(hi[15:0], 16'(4 * TK));
        chk(relay_drv & 16'hFFFE, 16'h7FFE);
    endtask
    task automatic t_phys();
        chan_phys_in = 16'h5AC3;
        wt(2 * TK);
        rd(8'h00, 0, 8'h00);
        chk(v, 16'h0000);
        wt(6 * TK);
        rd(8'h00, 0, 8'h00);
        chk(v, 16'h5AC3);
    endtask
    task automatic t_flags();
        rccu_gw_i.act(8'h05, 3, 8'h10, 8'h01, 8'h01);
        wt(4);
        chk(16'(status_byte), 16'h0081);
        pulse(clear_flags);
        wt(1);
        chk(16'(status_byte), 16'h0000);
        rd(8'h06, 1, 8'h20);
        chk(v, 16'h0000);
        chk(16'(status_byte), 16'h0080);
        pulse(clear_flags);
        rccu_gw_i.act(8'h07, 0, 8'h00, 8'h00, 8'h00);
        wt(4);
        chk(16'(status_byte), 16'h0080);
        pulse(clear_flags);
        drv_chain_fault = 1'b1;
        wt(8);
        drv_chain_fault = 1'b0;
        wt(8);
        chk(16'(status_byte), 16'h0040);
        pulse(clear_flags);
        wt(1);
        chk(16'(status_byte), 16'h0000);
    endtask
    task automatic t_reset_paths();
        rccu_gw_i.act(8'h03, 2, 8'h00, 8'h00, 8'h00);
        wt(4);
        chk(relay_drv, 16'h7FFE);
        wt(TK + 4);
        chk(relay_drv, 16'h7FFE);
        rccu_gw_i.act(8'h03, 2, 8'h02, 8'h00, 8'h00);
        pulse(restart_req);
        wt(2);
        chk(relay_drv, 16'h0000);
        rd(8'h04, 0, 8'h00);
        chk(v, 16'h0000);
        rccu_gw_i.act(8'h02, 2, 8'h01, 8'h00, 8'h00);
        wt(TK + 4);
        pulse(wdog_timeout);
        wt(2);
        chk(relay_drv, 16'h0000);
        // three silent steps restart the module
        comm_wdog_ticks = 16'h0003;
        pulse(clear_flags);
        rccu_gw_i.act(8'h02, 2, 8'h01, 8'h00, 8'h00);
        wt(TK + 4);
        chk(relay_drv, 16'h0001);
        wt(5 * TK);
        chk(relay_drv, 16'h0000);
        chk(16'(status_byte), 16'h0001);
    endtask
    // reset four cycles, then the scenarios
    initial begin
        reset_n = 1'b0;
        restart_req = 1'b0;
        wdog_timeout = 1'b0;
        clear_flags = 1'b0;
        drv_chain_fault = 1'b0;
        comm_wdog_ticks = 16'h0000;
        chan_phys_in = 16'h0000;
        repeat (4) @(posedge mclk);
        #1 reset_n = 1'b1;
        chk(relay_drv, 16'h0000);
        chk(16'(status_byte), 16'h0001);
        rd(8'h04, 0, 8'h00);
        chk(v, 16'h0000);
        t_drv();
        t_pwm();
        t_phys();
        t_flags();
        t_reset_paths();
        close_out();
    end
endmodule
